// *** dv/table_engine_model.sv ***
// stand-in for the switch table engine behind the access bank
// assumes one access outstanding; answer delay set by lat
`timescale 1ns/1ns
module table_engine_model (
  // clock and pacing
  input wire logic clk,
  input wire logic [3:0] lat,
  // table link
  input wire logic tbl_req,
  input wire logic [9:0] tbl_index,
  output logic tbl_ack,
  output logic [66:0] tbl_rdata
);
  logic [3:0] cnt_r;
  initial
  begin
    cnt_r = 4'h0;
    tbl_ack = 1'b0;
    tbl_rdata = 67'h0;
  end
  // outside an answer the data toggles, so stale data is never mistaken for valid
  always @(posedge clk)
  begin
    tbl_ack <= 1'b0;
    tbl_rdata <= ~tbl_rdata;
    if (tbl_req)
      cnt_r <= lat;
    else if (cnt_r != 4'h0)
      cnt_r <= cnt_r - 4'h1;
    if (!tbl_req && cnt_r == 4'h1)
    begin
      tbl_ack <= 1'b1;
      tbl_rdata <= {3'b101, 16'ha6b3, 16'h4732, 16'h3116, 6'h00, tbl_index};
    end
  end
endmodule : table_engine_model

// *** dv/tb.sv ***
// self-checking bench for the indirect switch-table access bank
// assumes the engine model answers every request after lat cycles
`timescale 1ns/1ns
module tb;
  import table_access_pkg::*;
  logic clk, nrst, reg_wr, reg_rd, tbl_req, tbl_read, tbl_ack;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, v;
  logic [1:0] tbl_sel;
  logic [9:0] tbl_index;
  logic [66:0] tbl_wdata, tbl_rdata;
  logic [3:0] lat;
  int n_mismatch, compares;
  switch_table_indirect_access dut (.clk, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .tbl_req, .tbl_read, .tbl_sel, .tbl_index, .tbl_wdata, .tbl_ack, .tbl_rdata);
  table_engine_model eng (.clk, .lat, .tbl_req, .tbl_index, .tbl_ack, .tbl_rdata);
  task automatic give_verdict;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [66:0] got, input logic [66:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  // one command, then wait for it to finish; slow reads are polled, then every command waits a fixed 16 cycles
  task automatic go(input logic [15:0] c);
    int k;
    k = 0;
    wr(OFF_CMD, c);
    chk(tbl_req, 1);
    chk({tbl_read, tbl_sel, tbl_index}, c[12:0]);
    rd(OFF_TOP, v);
    chk(v[7], c[12] & c[11]);
    while (v[7] !== 1'b0 && k < 20)
    begin
      rd(OFF_TOP, v);
      k++;
    end
    repeat (16) @(posedge clk);
    #1;
    if (k >= 20)
    begin
      n_mismatch++;
      $display("[FAIL] %0t pending flag never cleared", $time);
      give_verdict();
    end
  endtask : go
  task automatic t_regs;
    for (int i = 0; i < 7; i++)
    begin
      rd(8'(2 * i), v);
      chk(v, 0);
      if (i > 0)
        wr(8'(2 * i), 16'ha5a0 + 16'(i));
    end
    for (int i = 1; i < 7; i++)
    begin
      rd(8'(2 * i), v);
      chk(v, (i == 1 || i == 6) ? 16'h0000 : 16'ha5a0 + 16'(i));
    end
    $display("test regs done");
  endtask : t_regs
  task automatic t_write;
    for (int s = 0; s < 4; s++)
    begin
      lat <= 4'(1 + 4 * s);
      go({3'b000, 1'b0, 2'(s), 10'(100 + s)});
      chk(tbl_wdata, {3'b000, 16'ha5a3, 16'ha5a2, 16'ha5a5, 16'ha5a4});
      rd(OFF_CMD, v);
      chk(tbl_req, 0);
      chk(v, {6'h00, 10'(100 + s)} | (16'(s) << 10));
    end
    $display("test write done");
  endtask : t_write
  task automatic t_read;
    for (int s = 0; s < 4; s++)
    begin
      lat <= 4'(1 + 4 * s);
      go({3'b000, 1'b1, 2'(s), 10'(s * 300)});
      rd(OFF_D15_0, v);
      chk(v, {6'h00, 10'(s * 300)});
      rd(OFF_D31_16, v);
      chk(v, 16'h3116);
      rd(OFF_D47_32, v);
      chk(v, 16'h4732);
      rd(OFF_D63_48, v);
      chk(v, 16'ha6b3);
      rd(OFF_TOP, v);
      chk(v, 16'h0005);
    end
    $display("test read done");
  endtask : t_read
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    lat = 4'h1;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_write();
    t_read();
    give_verdict();
  end
endmodule : tb

// *** verilog/data_word_reg.sv ***
// one 16-bit host-writable data word that the table side can also load
// assumes load and host write never both matter in one cycle; load wins
`timescale 1ns/1ns
module data_word_reg
  import table_access_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // host and table side
  input wire logic host_we,
  input wire logic [15:0] host_data,
  input wire logic load,
  input wire logic [15:0] load_data,
  output logic [15:0] q
);
  typedef struct packed {
    logic [15:0] word;
  } word_s;
  word_s st_r;
  word_s st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (load)
      st_nxt.word = load_data;
    else if (host_we)
      st_nxt.word = host_data;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      st_r <= '{word: DATA_RESET};
    else
      st_r <= st_nxt;
  end

  assign q = st_r.word;
endmodule : data_word_reg

// *** verilog/switch_table_indirect_access.sv ***
// indirect access port to the switch tables: command word, five data words
// assumes a synchronous 16-bit register port and a table engine with req/ack
`timescale 1ns/1ns
module switch_table_indirect_access
  import table_access_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // host register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // table engine
  output logic tbl_req,
  output logic tbl_read,
  output logic [1:0] tbl_sel,
  output logic [9:0] tbl_index,
  output logic [66:0] tbl_wdata,
  input wire logic tbl_ack,
  input wire logic [66:0] tbl_rdata
);
  typedef struct packed {
    logic [15:0] cmd;
    logic [2:0] top;
    logic pend;
    logic req;
    access_state_e state;
    logic [15:0] rdata;
  } ctl_s;
  ctl_s st_r;
  ctl_s st_nxt;

  logic [15:0] w47_32;
  logic [15:0] w63_48;
  logic [15:0] w15_0;
  logic [15:0] w31_16;
  logic load;
  logic cmd_wr;
  logic slow_read;

  assign cmd_wr = reg_wr && (reg_addr == OFF_CMD);
  assign load = (st_r.state == ST_WAIT) && tbl_ack && st_r.cmd[DIR_BIT];
  // dynamic and counter tables sit behind a slow engine, so only reads of them raise pending
  assign slow_read = reg_wdata[DIR_BIT] && reg_wdata[SEL_HI];

  data_word_reg u_w47_32 (.clk(clk), .nrst(nrst),
    .host_we(reg_wr && reg_addr == OFF_D47_32), .host_data(reg_wdata),
    .load(load), .load_data(tbl_rdata[47:32]), .q(w47_32));
  data_word_reg u_w63_48 (.clk(clk), .nrst(nrst),
    .host_we(reg_wr && reg_addr == OFF_D63_48), .host_data(reg_wdata),
    .load(load), .load_data(tbl_rdata[63:48]), .q(w63_48));
  data_word_reg u_w15_0 (.clk(clk), .nrst(nrst),
    .host_we(reg_wr && reg_addr == OFF_D15_0), .host_data(reg_wdata),
    .load(load), .load_data(tbl_rdata[15:0]), .q(w15_0));
  data_word_reg u_w31_16 (.clk(clk), .nrst(nrst),
    .host_we(reg_wr && reg_addr == OFF_D31_16), .host_data(reg_wdata),
    .load(load), .load_data(tbl_rdata[31:16]), .q(w31_16));

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.req = 1'b0;
    case (st_r.state)
      ST_IDLE:
      begin
        if (cmd_wr)
        begin
          st_nxt.cmd = reg_wdata & CMD_WMASK;
          st_nxt.req = 1'b1;
          st_nxt.pend = slow_read;
          st_nxt.state = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        // a command written while busy is dropped: the engine takes one at a time
        if (tbl_ack)
        begin
          if (st_r.cmd[DIR_BIT])
            st_nxt.top = tbl_rdata[66:64];
          st_nxt.pend = 1'b0;
          st_nxt.state = ST_IDLE;
        end
      end
      default:
        st_nxt.state = ST_IDLE;
    endcase
    st_nxt.rdata = 16'h0000;
    if (reg_rd)
    begin
      case (reg_addr)
        OFF_CMD: st_nxt.rdata = st_r.cmd;
        OFF_TOP: st_nxt.rdata = {8'h00, st_nxt.pend, 4'h0, st_nxt.top};
        OFF_D47_32: st_nxt.rdata = w47_32;
        OFF_D63_48: st_nxt.rdata = w63_48;
        OFF_D15_0: st_nxt.rdata = w15_0;
        OFF_D31_16: st_nxt.rdata = w31_16;
        default: st_nxt.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      st_r <= '{cmd: CMD_RESET, top: 3'h0, pend: 1'b0, req: 1'b0,
                state: ST_IDLE, rdata: 16'h0000};
    else
      st_r <= st_nxt;
  end

  assign reg_rdata = st_r.rdata;
  assign tbl_req = st_r.req;
  assign tbl_read = st_r.cmd[DIR_BIT];
  assign tbl_sel = st_r.cmd[SEL_HI:SEL_LO];
  assign tbl_index = st_r.cmd[IDX_HI:0];
  // write data follows the words as they stand; it is not held while the request is out
  assign tbl_wdata = {st_r.top, w63_48, w47_32, w31_16, w15_0};

  sequence s_launch;
    cmd_wr && st_r.state == ST_IDLE;
  endsequence
  sequence s_slow_launch;
    cmd_wr && st_r.state == ST_IDLE && reg_wdata[DIR_BIT] && reg_wdata[SEL_HI];
  endsequence

  AST_CMD_LAUNCH: assert property (@(posedge clk) disable iff (!nrst)
    s_launch |=> tbl_req && st_r.state == ST_WAIT)
    else $error("command write did not launch access");
  AST_READ_NO_LAUNCH: assert property (@(posedge clk) disable iff (!nrst)
    !(cmd_wr && st_r.state == ST_IDLE) |=> !tbl_req)
    else $error("access launched without command write");
  AST_DIR: assert property (@(posedge clk) disable iff (!nrst)
    s_launch |=> tbl_read == $past(reg_wdata[DIR_BIT]))
    else $error("direction bit not applied");
  AST_SEL: assert property (@(posedge clk) disable iff (!nrst)
    s_launch |=> tbl_sel == $past(reg_wdata[SEL_HI:SEL_LO]))
    else $error("table select not applied");
  AST_INDEX: assert property (@(posedge clk) disable iff (!nrst)
    s_launch |=> tbl_index == $past(reg_wdata[IDX_HI:0]))
    else $error("index not applied");
  AST_PEND_SET: assert property (@(posedge clk) disable iff (!nrst)
    s_slow_launch |=> st_r.pend)
    else $error("pending not raised for slow read");
  AST_PEND_CLR: assert property (@(posedge clk) disable iff (!nrst)
    st_r.state == ST_WAIT && tbl_ack |=> !st_r.pend && st_r.state == ST_IDLE)
    else $error("pending not cleared on completion");
  AST_TOP_LOAD: assert property (@(posedge clk) disable iff (!nrst)
    load |=> st_r.top == $past(tbl_rdata[66:64]))
    else $error("top bits not captured");
  AST_TOP_RO: assert property (@(posedge clk) disable iff (!nrst)
    !load |=> st_r.top == $past(st_r.top))
    else $error("top bits changed without table read");
  AST_LOW_LOAD: assert property (@(posedge clk) disable iff (!nrst)
    load |=> w15_0 == $past(tbl_rdata[15:0]) && w31_16 == $past(tbl_rdata[31:16]))
    else $error("low data words not loaded");
  AST_HIGH_WRITE: assert property (@(posedge clk) disable iff (!nrst)
    reg_wr && reg_addr == OFF_D63_48 && !load |=> w63_48 == $past(reg_wdata))
    else $error("data word 63:48 not written");
  AST_MID_WRITE: assert property (@(posedge clk) disable iff (!nrst)
    reg_wr && reg_addr == OFF_D47_32 && !load |=> w47_32 == $past(reg_wdata))
    else $error("data word 47:32 not written");
  AST_W31_WRITE: assert property (@(posedge clk) disable iff (!nrst)
    reg_wr && reg_addr == OFF_D31_16 && !load |=> w31_16 == $past(reg_wdata))
    else $error("data word 31:16 not written");

  // a busy engine takes one command at a time, so a late command must leave no trace
  sequence s_busy_cmd;
    cmd_wr && st_r.state == ST_WAIT;
  endsequence
  sequence s_fast_launch;
    cmd_wr && st_r.state == ST_IDLE && !(reg_wdata[DIR_BIT] && reg_wdata[SEL_HI]);
  endsequence
  sequence s_rd_cmd;
    reg_rd && reg_addr == OFF_CMD;
  endsequence
  sequence s_rd_top;
    reg_rd && reg_addr == OFF_TOP;
  endsequence
  sequence s_slow_done;
    st_r.state == ST_WAIT && tbl_ack && st_r.pend;
  endsequence

  AST_BUSY_DROP: assert property (@(posedge clk) disable iff (!nrst)
    s_busy_cmd |=> !tbl_req && st_r.cmd == $past(st_r.cmd))
    else $error("command written while busy was not dropped");
  AST_REQ_PULSE: assert property (@(posedge clk) disable iff (!nrst)
    tbl_req |=> !tbl_req)
    else $error("request longer than one cycle");
  AST_RD_NO_LAUNCH: assert property (@(posedge clk) disable iff (!nrst)
    reg_rd && !cmd_wr |=> !tbl_req)
    else $error("register read launched an access");
  AST_WAIT_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    st_r.state == ST_WAIT && !tbl_ack |=> st_r.state == ST_WAIT)
    else $error("access ended without acknowledge");

  AST_DIR_STABLE: assert property (@(posedge clk) disable iff (!nrst)
    st_r.state == ST_WAIT |=> $stable(tbl_read))
    else $error("direction changed during access");
  AST_SEL_STABLE: assert property (@(posedge clk) disable iff (!nrst)
    st_r.state == ST_WAIT |=> $stable(tbl_sel))
    else $error("table select changed during access");
  AST_INDEX_STABLE: assert property (@(posedge clk) disable iff (!nrst)
    st_r.state == ST_WAIT |=> $stable(tbl_index))
    else $error("index changed during access");
  AST_RD_CMD: assert property (@(posedge clk) disable iff (!nrst)
    s_rd_cmd |=> reg_rdata == $past(st_r.cmd))
    else $error("command readback wrong");
  AST_CMD_RSVD: assert property (@(posedge clk) disable iff (!nrst)
    s_rd_cmd |=> reg_rdata[15:13] == 3'h0)
    else $error("reserved command bits not zero");

  AST_PEND_FAST: assert property (@(posedge clk) disable iff (!nrst)
    s_fast_launch |=> !st_r.pend)
    else $error("pending raised for fast access");
  AST_PEND_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    st_r.pend && !tbl_ack |=> st_r.pend)
    else $error("pending dropped before completion");
  AST_PEND_IDLE: assert property (@(posedge clk) disable iff (!nrst)
    st_r.state == ST_IDLE |-> !st_r.pend)
    else $error("pending high while idle");
  AST_RD_PEND: assert property (@(posedge clk) disable iff (!nrst)
    s_rd_top |=> reg_rdata[7] == st_r.pend)
    else $error("pending readback wrong");
  AST_RD_PEND_DONE: assert property (@(posedge clk) disable iff (!nrst)
    reg_rd && reg_addr == OFF_TOP && st_r.state == ST_WAIT && tbl_ack |=> !reg_rdata[7])
    else $error("pending read high in completion cycle");
  AST_SLOW_SET_RD: assert property (@(posedge clk) disable iff (!nrst)
    s_slow_launch ##1 (reg_rd && reg_addr == OFF_TOP && !tbl_ack) |=> reg_rdata[7])
    else $error("pending not shown during slow read");
  AST_FAST_RD: assert property (@(posedge clk) disable iff (!nrst)
    s_fast_launch ##1 (reg_rd && reg_addr == OFF_TOP) |=> !reg_rdata[7])
    else $error("pending shown for fast access");
  AST_SLOW_DONE: assert property (@(posedge clk) disable iff (!nrst)
    s_slow_done |=> !st_r.pend && st_r.top == $past(tbl_rdata[66:64]))
    else $error("slow read did not complete cleanly");

  AST_RD_TOP: assert property (@(posedge clk) disable iff (!nrst)
    s_rd_top |=> reg_rdata[2:0] == st_r.top)
    else $error("top bits readback wrong");
  AST_RD_TOP_RSVD: assert property (@(posedge clk) disable iff (!nrst)
    s_rd_top |=> reg_rdata[15:8] == 8'h00 && reg_rdata[6:3] == 4'h0)
    else $error("reserved status bits not zero");
  AST_TOP_HOST_RO: assert property (@(posedge clk) disable iff (!nrst)
    reg_wr && reg_addr == OFF_TOP && !load |=> st_r.top == $past(st_r.top))
    else $error("host write changed top bits");
  AST_IDLE_ACK: assert property (@(posedge clk) disable iff (!nrst)
    st_r.state == ST_IDLE && tbl_ack |=> st_r.top == $past(st_r.top))
    else $error("stray acknowledge loaded top bits");

  AST_MID_LOAD: assert property (@(posedge clk) disable iff (!nrst)
    load |=> w47_32 == $past(tbl_rdata[47:32]))
    else $error("data word 47:32 not loaded");
  AST_RD_W47: assert property (@(posedge clk) disable iff (!nrst)
    reg_rd && reg_addr == OFF_D47_32 |=> reg_rdata == $past(w47_32))
    else $error("data word 47:32 readback wrong");
  AST_MID_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    !load && !(reg_wr && reg_addr == OFF_D47_32) |=> $stable(w47_32))
    else $error("data word 47:32 changed by itself");

  AST_HIGH_LOAD: assert property (@(posedge clk) disable iff (!nrst)
    load |=> w63_48 == $past(tbl_rdata[63:48]))
    else $error("data word 63:48 not loaded");
  AST_RD_W63: assert property (@(posedge clk) disable iff (!nrst)
    reg_rd && reg_addr == OFF_D63_48 |=> reg_rdata == $past(w63_48))
    else $error("data word 63:48 readback wrong");
  AST_HIGH_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    !load && !(reg_wr && reg_addr == OFF_D63_48) |=> $stable(w63_48))
    else $error("data word 63:48 changed by itself");

  AST_LOW_WRITE: assert property (@(posedge clk) disable iff (!nrst)
    reg_wr && reg_addr == OFF_D15_0 && !load |=> w15_0 == $past(reg_wdata))
    else $error("data word 15:0 not written");
  AST_RD_W15: assert property (@(posedge clk) disable iff (!nrst)
    reg_rd && reg_addr == OFF_D15_0 |=> reg_rdata == $past(w15_0))
    else $error("data word 15:0 readback wrong");
  AST_LOW_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    !load && !(reg_wr && reg_addr == OFF_D15_0) |=> $stable(w15_0))
    else $error("data word 15:0 changed by itself");

  AST_W31_LOAD: assert property (@(posedge clk) disable iff (!nrst)
    load |=> w31_16 == $past(tbl_rdata[31:16]))
    else $error("data word 31:16 not loaded");
  AST_RD_W31: assert property (@(posedge clk) disable iff (!nrst)
    reg_rd && reg_addr == OFF_D31_16 |=> reg_rdata == $past(w31_16))
    else $error("data word 31:16 readback wrong");
  AST_W31_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    !load && !(reg_wr && reg_addr == OFF_D31_16) |=> $stable(w31_16))
    else $error("data word 31:16 changed by itself");
endmodule : switch_table_indirect_access

// *** verilog/table_access_pkg.sv ***
// constants for the indirect switch-table access register bank
// assumes a 16-bit host register port, byte offsets as printed
package table_access_pkg;
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_TOP = 8'h02;
  localparam logic [7:0] OFF_D47_32 = 8'h04;
  localparam logic [7:0] OFF_D63_48 = 8'h06;
  localparam logic [7:0] OFF_D15_0 = 8'h08;
  localparam logic [7:0] OFF_D31_16 = 8'h0a;
  localparam int DIR_BIT = 12;
  localparam int SEL_HI = 11;
  localparam int SEL_LO = 10;
  localparam int IDX_HI = 9;
  localparam int PEND_BIT = 7;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic [15:0] CMD_WMASK = 16'h1fff;
  localparam int DATA_W = 67;
  localparam int IDX_W = 10;
  typedef enum logic [1:0] {
    SEL_STATIC = 2'b00,
    SEL_VLAN = 2'b01,
    SEL_DYNAMIC = 2'b10,
    SEL_COUNTERS = 2'b11
  } table_sel_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01
  } access_state_e;
endpackage : table_access_pkg
